/* common/lcfg_pkg.sv */
// Constants for the laser channel configuration register bank
package lcfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CFG_N  = 7;

    // Register offsets
    localparam logic [7:0] OFF_STATUS    = 8'h00;
    localparam logic [7:0] OFF_MODE_ADC  = 8'h10;
    localparam logic [7:0] OFF_OC_THR    = 8'h11;
    localparam logic [7:0] OFF_MON_RES   = 8'h12;
    localparam logic [7:0] OFF_LOOP_REFH = 8'h13;
    localparam logic [7:0] OFF_REF_LOW   = 8'h14;
    localparam logic [7:0] OFF_CONV_GAIN = 8'h15;
    localparam logic [7:0] OFF_MASK_SIM  = 8'h16;
    localparam logic [7:0] OFF_OP_STATE  = 8'h1C;

    // Array indices of the configuration registers
    localparam int IDX_MODE_ADC  = 0;
    localparam int IDX_OC_THR    = 1;
    localparam int IDX_MON_RES   = 2;
    localparam int IDX_LOOP_REFH = 3;
    localparam int IDX_REF_LOW   = 4;
    localparam int IDX_CONV_GAIN = 5;
    localparam int IDX_MASK_SIM  = 6;

    // Reset values
    localparam logic [7:0] RST_MODE_ADC  = 8'h08;
    localparam logic [7:0] RST_OC_THR    = 8'h00;
    localparam logic [7:0] RST_MON_RES   = 8'hFF;
    localparam logic [7:0] RST_LOOP_REFH = 8'h40;
    localparam logic [7:0] RST_REF_LOW   = 8'h00;
    localparam logic [7:0] RST_CONV_GAIN = 8'h00;
    localparam logic [7:0] RST_MASK_SIM  = 8'h06;
    localparam logic [7:0] RST_OP_STATE  = 8'h05;

    // Writable bit masks; others read as zero
    localparam logic [7:0] WMASK_LOOP_REFH = 8'hDF;
    localparam logic [7:0] WMASK_MASK_SIM  = 8'hBF;
    localparam logic [7:0] WMASK_OP_STATE  = 8'h07;

    // Field positions, register channel_mode_adc_ctrl
    localparam int BIT_REG_MODE   = 0;
    localparam int BIT_CONV_EN    = 1;
    localparam int BIT_RES_DIS    = 2;
    localparam int BIT_CH_LOCK    = 3;
    localparam int ADC_SRC_LSB    = 5;
    // Register loop_config_ref_high
    localparam int REFH_LSB       = 0;
    localparam int BIT_SENSE_RNG  = 2;
    localparam int BIT_MOD_EN     = 3;
    localparam int BIT_VRN_RANGE  = 4;
    localparam int BIT_REF_SWAP   = 6;
    localparam int BIT_LASER_POL  = 7;
    // Register converter_current_gain
    localparam int CONV_CUR_LSB   = 0;
    localparam int SENSE_GAIN_LSB = 6;
    // Register masks_simulation_ctrl
    localparam int BIT_OSC_MASK   = 0;
    localparam int BIT_CHON_MASK  = 1;
    localparam int BIT_ADC_DIV    = 2;
    localparam int BIT_REF_CURVE  = 3;
    localparam int BIT_SIM_OT     = 4;
    localparam int BIT_SIM_OC     = 5;
    localparam int BIT_SIM_OSC    = 7;
    // Register operating_state_ctrl
    localparam int OPST_LSB       = 0;
    localparam int BIT_ANIN_HIZ   = 2;
    // Status register 0x00
    localparam int BIT_MEM_ERR    = 2;
    localparam int BIT_OC_FLAG    = 5;

    // Operating state codes
    localparam logic [1:0] OPST_OPERATE = 2'h1;
    localparam logic [1:0] OPST_CONFIG  = 2'h2;

    // Sense gain factors by code
    localparam logic [5:0] GAIN_C0 = 6'h02;
    localparam logic [5:0] GAIN_C1 = 6'h05;
    localparam logic [5:0] GAIN_C2 = 6'h0A;
    localparam logic [5:0] GAIN_C3 = 6'h32;

    localparam logic [CFG_N-1:0][7:0] CFG_RESET = {
        RST_MASK_SIM, RST_CONV_GAIN, RST_REF_LOW, RST_LOOP_REFH,
        RST_MON_RES, RST_OC_THR, RST_MODE_ADC
    };

    localparam int SYNC_N = 3;

endpackage

/* common/lcfg_cfg_if.sv */
// Carrier between the register bank and the active settings hold
`timescale 1ns/100ps
interface lcfg_cfg_if;
    import lcfg_pkg::*;

    logic [CFG_N-1:0][7:0] shadow;
    logic [CFG_N-1:0][7:0] active;
    logic                  apply;

    modport bank (output shadow, output apply, input active);
    modport hold (input shadow, input apply, output active);
endinterface

/* core/lcfg_hold.sv */
// Active channel settings, loaded from the written registers
`timescale 1ns/100ps
module lcfg_hold (
    input  wire logic   clk_sys_in,
    input  wire logic   rst_b_in,
    lcfg_cfg_if.hold    cfg
);
    import lcfg_pkg::*;

    logic [CFG_N-1:0][7:0] active_ff;

    // Transparent in operation mode, frozen otherwise
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            active_ff <= CFG_RESET;
        end else if (cfg.apply) begin
            active_ff <= cfg.shadow;
        end
    end

    assign cfg.active = active_ff;
endmodule // lcfg_hold

/* core/lcfg_top.sv */
// Laser channel configuration register bank top
`timescale 1ns/100ps
module lcfg_top (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_b_in,
    // Register access from the serial interface engine
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    input  wire logic [lcfg_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [lcfg_pkg::DATA_W-1:0] reg_wdata_in,
    output logic      [lcfg_pkg::DATA_W-1:0] reg_rdata_out,
    output logic                          reg_rvalid_out,
    // Pins and analog events
    input  wire logic                     external_enable_pin_b_in,
    input  wire logic                     overcurrent_event_in,
    input  wire logic                     overtemp_event_in,
    input  wire logic                     osc_fault_event_in,
    // Active channel settings
    output logic                          regulation_mode_select_out,
    output logic                          converter_enable_out,
    output logic [2:0]                    adc_source_select_out,
    output logic                          resistor_disable_out,
    output logic [7:0]                    overcurrent_threshold_out,
    output logic                          overcurrent_detect_en_out,
    output logic [7:0]                    programmable_resistor_out,
    output logic [9:0]                    reference_code_out,
    output logic                          sense_range_select_out,
    output logic                          modulation_enable_out,
    output logic                          vrn_range_select_out,
    output logic                          reference_swap_out,
    output logic                          laser_polarity_select_out,
    output logic [5:0]                    converter_current_code_out,
    output logic [1:0]                    sense_gain_out,
    output logic [5:0]                    sense_gain_factor_out,
    output logic                          adc_divider_enable_out,
    output logic                          reference_curve_select_out,
    output logic                          anin_hiz_out,
    // Channel state and fault signalling
    output logic                          channel_enabled_state_out,
    output logic                          overtemp_active_out,
    output logic                          overcurrent_active_out,
    output logic                          osc_fault_active_out,
    output logic                          fault_check_output_b_out,
    output logic                          memory_error_flag_out,
    output logic                          overcurrent_flag_out
);
    import lcfg_pkg::*;

    // Configuration index of an address; CFG_N when not a config register
    function automatic logic [2:0] cfg_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFF_MODE_ADC;
        if (a >= OFF_MODE_ADC && a <= OFF_MASK_SIM) begin
            cfg_index = d[2:0];
        end else begin
            cfg_index = 3'(CFG_N);
        end
    endfunction

    function automatic logic [7:0] cfg_wmask(input logic [2:0] i);
        case (i)
            3'(IDX_LOOP_REFH): cfg_wmask = WMASK_LOOP_REFH;
            3'(IDX_MASK_SIM):  cfg_wmask = WMASK_MASK_SIM;
            default:           cfg_wmask = 8'hFF;
        endcase
    endfunction

    function automatic logic [5:0] gain_factor(input logic [1:0] c);
        case (c)
            2'h0:    gain_factor = GAIN_C0;
            2'h1:    gain_factor = GAIN_C1;
            2'h2:    gain_factor = GAIN_C2;
            default: gain_factor = GAIN_C3;
        endcase
    endfunction

    lcfg_cfg_if cfg ();

    lcfg_hold u_hold (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .cfg        (cfg)
    );

    // Written register images
    logic [CFG_N-1:0][7:0] shadow_ff;
    logic [7:0]            op_state_ff;
    logic [7:0]            rdata_ff;
    logic                  rvalid_ff;
    logic                  mem_err_ff;
    logic                  oc_flag_ff;

    // Pin synchronisers: three stages, filtered value
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [3:0] pin_ff;

    // Registered derived outputs
    logic       ch_on_ff;
    logic       ot_ff;
    logic       oc_ff;
    logic       osc_ff;
    logic       chk_b_ff;
    logic       oc_det_ff;
    logic [5:0] gain_fac_ff;

    // Decode of register access
    wire logic [2:0] wr_idx     = cfg_index(reg_addr_in);
    wire logic       cfg_hit    = (wr_idx != 3'(CFG_N));
    wire logic       cfg_wr     = reg_wr_in && cfg_hit;
    wire logic       opst_wr    = reg_wr_in && (reg_addr_in == OFF_OP_STATE);
    wire logic       status_rd  = reg_rd_in && (reg_addr_in == OFF_STATUS);
    wire logic [7:0] wr_mask    = cfg_wmask(wr_idx);
    wire logic [7:0] wr_masked  = reg_wdata_in & wr_mask;

    // Operating state
    wire logic [1:0] opst       = op_state_ff[OPST_LSB +: 2];
    wire logic       in_operate = (opst == OPST_OPERATE);
    wire logic       opst_bad   = (opst != OPST_OPERATE) &&
                                  (opst != OPST_CONFIG);

    // Active register views
    wire logic [7:0] a_mode = cfg.active[IDX_MODE_ADC];
    wire logic [7:0] a_thr  = cfg.active[IDX_OC_THR];
    wire logic [7:0] a_res  = cfg.active[IDX_MON_RES];
    wire logic [7:0] a_refh = cfg.active[IDX_LOOP_REFH];
    wire logic [7:0] a_refl = cfg.active[IDX_REF_LOW];
    wire logic [7:0] a_conv = cfg.active[IDX_CONV_GAIN];
    wire logic [7:0] a_msk  = cfg.active[IDX_MASK_SIM];

    // Filtered pins
    wire logic ext_en_req = ~pin_ff[0];
    wire logic oc_pin     = pin_ff[1];
    wire logic ot_pin     = pin_ff[2];
    wire logic osc_pin    = pin_ff[3];

    // Events, including simulated ones
    wire logic oc_det_en  = (a_thr != 8'h00);
    // Loaded in step with the hold so the output never lags the threshold
    wire logic nxt_oc_det = in_operate ?
                            (shadow_ff[IDX_OC_THR] != 8'h00) :
                            oc_det_en;
    wire logic oc_event   = (oc_pin && oc_det_en) ||
                            a_msk[BIT_SIM_OC];
    wire logic ot_event   = ot_pin || a_msk[BIT_SIM_OT];
    wire logic osc_event  = osc_pin || a_msk[BIT_SIM_OSC];

    // Channel on only with pin request, unlocked and no overcurrent or overtemperature event
    wire logic nxt_ch_on  = ext_en_req && !a_mode[BIT_CH_LOCK] &&
                            !oc_event && !ot_event;
    wire logic nxt_chk_b  = !((osc_event && !a_msk[BIT_OSC_MASK]) ||
                              (nxt_ch_on && !a_msk[BIT_CHON_MASK]));

    // Memory error: set wins over validation by operation mode
    wire logic mem_err_set = opst_bad || (cfg_wr && !in_operate);
    wire logic nxt_mem_err = mem_err_set || (mem_err_ff && !in_operate);

    // Overcurrent sticky flag: set wins over read clear
    wire logic nxt_oc_flag = oc_event || (oc_flag_ff && !status_rd);

    wire logic [7:0] status_val = (8'(mem_err_ff) << BIT_MEM_ERR) |
                                  (8'(oc_flag_ff) << BIT_OC_FLAG);
    wire logic [7:0] nxt_rdata  = (reg_addr_in == OFF_STATUS)   ? status_val :
                                  cfg_hit                       ?
                                      shadow_ff[wr_idx]         :
                                  (reg_addr_in == OFF_OP_STATE) ? op_state_ff :
                                  8'h00;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shadow_ff <= CFG_RESET;
        end else if (cfg_wr) begin
            shadow_ff[wr_idx] <= wr_masked;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            op_state_ff <= RST_OP_STATE;
        end else if (opst_wr) begin
            op_state_ff <= reg_wdata_in & WMASK_OP_STATE;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mem_err_ff <= 1'b0;
            oc_flag_ff <= 1'b0;
        end else begin
            mem_err_ff <= nxt_mem_err;
            oc_flag_ff <= nxt_oc_flag;
        end
    end

    // Filter accepts a change only when stages two and three agree
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_ff <= 4'h1;
            sync2_ff <= 4'h1;
            sync3_ff <= 4'h1;
            pin_ff   <= 4'h1;
        end else begin
            sync1_ff <= {osc_fault_event_in, overtemp_event_in,
                         overcurrent_event_in, external_enable_pin_b_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < 4; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ch_on_ff    <= 1'b0;
            ot_ff       <= 1'b0;
            oc_ff       <= 1'b0;
            osc_ff      <= 1'b0;
            chk_b_ff    <= 1'b1;
            oc_det_ff   <= 1'b0;
            gain_fac_ff <= GAIN_C0;
        end else begin
            oc_det_ff   <= nxt_oc_det;
            ch_on_ff    <= nxt_ch_on;
            ot_ff       <= ot_event;
            oc_ff       <= oc_event;
            osc_ff      <= osc_event;
            chk_b_ff    <= nxt_chk_b;
            gain_fac_ff <= gain_factor(a_conv[SENSE_GAIN_LSB +: 2]);
        end
    end

    // Hold is transparent only in operation mode
    assign cfg.shadow = shadow_ff;
    assign cfg.apply  = in_operate;

    assign reg_rdata_out  = rdata_ff;
    assign reg_rvalid_out = rvalid_ff;

    assign regulation_mode_select_out = a_mode[BIT_REG_MODE];
    assign converter_enable_out       = a_mode[BIT_CONV_EN];
    assign adc_source_select_out      = a_mode[ADC_SRC_LSB +: 3];
    assign resistor_disable_out       = a_mode[BIT_RES_DIS];
    assign overcurrent_threshold_out  = a_thr;
    assign overcurrent_detect_en_out  = oc_det_ff;
    assign programmable_resistor_out  = a_res;
    assign reference_code_out         = {a_refh[REFH_LSB +: 2], a_refl};
    assign sense_range_select_out     = a_refh[BIT_SENSE_RNG];
    assign modulation_enable_out      = a_refh[BIT_MOD_EN];
    assign vrn_range_select_out       = a_refh[BIT_VRN_RANGE];
    assign reference_swap_out         = a_refh[BIT_REF_SWAP];
    assign laser_polarity_select_out  = a_refh[BIT_LASER_POL];
    assign converter_current_code_out = a_conv[CONV_CUR_LSB +: 6];
    assign sense_gain_out             = a_conv[SENSE_GAIN_LSB +: 2];
    assign sense_gain_factor_out      = gain_fac_ff;
    assign adc_divider_enable_out     = a_msk[BIT_ADC_DIV];
    assign reference_curve_select_out = a_msk[BIT_REF_CURVE];
    assign anin_hiz_out               = op_state_ff[BIT_ANIN_HIZ];

    assign channel_enabled_state_out  = ch_on_ff;
    assign overtemp_active_out        = ot_ff;
    assign overcurrent_active_out     = oc_ff;
    assign osc_fault_active_out       = osc_ff;
    assign fault_check_output_b_out   = chk_b_ff;
    assign memory_error_flag_out      = mem_err_ff;
    assign overcurrent_flag_out       = oc_flag_ff;

endmodule // lcfg_top

/* sim/lcfg_monitor.sv */
// Port-level checker for the configuration bank top
`timescale 1ns/100ps
module lcfg_monitor
    import lcfg_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       rst_b_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_rvalid_out,
    input wire logic       external_enable_pin_b_in,
    input wire logic [7:0] overcurrent_threshold_out,
    input wire logic       overcurrent_detect_en_out,
    input wire logic [9:0] reference_code_out,
    input wire logic [1:0] sense_gain_out,
    input wire logic [5:0] sense_gain_factor_out,
    input wire logic       channel_enabled_state_out,
    input wire logic       overcurrent_active_out,
    input wire logic       osc_fault_active_out,
    input wire logic       fault_check_output_b_out,
    input wire logic       memory_error_flag_out,
    input wire logic       overcurrent_flag_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    // Shadow of the mode field, rebuilt from the writes seen
    logic [1:0] mode_ff;
    wire logic  wr_mode = reg_wr_in && reg_addr_in == OFF_OP_STATE;
    wire logic  op_mode = mode_ff == OPST_OPERATE;
    wire logic [5:0] exp_gain = sense_gain_out == 2'h0 ? 6'h02 :
                                sense_gain_out == 2'h1 ? 6'h05 :
                                sense_gain_out == 2'h2 ? 6'h0A : 6'h32;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_ff <= 2'h1;
        end else if (wr_mode) begin
            mode_ff <= reg_wdata_in[1:0];
        end
    end

    AST_OC_DETECT: assert property (
        overcurrent_detect_en_out == (overcurrent_threshold_out != 8'h00))
        else $error("overcurrent detect enable disagrees with threshold");
    AST_REF_APPLY: assert property (
        (reg_wr_in && reg_addr_in == OFF_REF_LOW && op_mode) ##1
        (!wr_mode && op_mode) |=>
        reference_code_out[7:0] == $past(reg_wdata_in, 2))
        else $error("reference low byte not applied two edges on");
    AST_FROZEN: assert property (
        !op_mode && !wr_mode && $past(mode_ff) != OPST_OPERATE
        |=> $stable(reference_code_out))
        else $error("active reference moved outside operation mode");
    AST_MEM_ERR: assert property (
        mode_ff[0] == mode_ff[1] |-> ##[1:2] memory_error_flag_out)
        else $error("forbidden mode code without memory error");
    AST_GAIN: assert property (
        1'b1 |=> sense_gain_factor_out == $past(exp_gain))
        else $error("gain factor does not follow gain code");
    AST_OC_STICKY: assert property (
        overcurrent_active_out |-> ##[0:2] overcurrent_flag_out)
        else $error("overcurrent did not set the sticky flag");
    AST_NO_REQUEST: assert property (
        external_enable_pin_b_in [*8] |-> !channel_enabled_state_out)
        else $error("channel on without pin request");
    AST_FAULT_CAUSE: assert property (
        !fault_check_output_b_out |-> osc_fault_active_out ||
        channel_enabled_state_out || $past(osc_fault_active_out) ||
        $past(channel_enabled_state_out))
        else $error("fault check low without a cause");
    AST_READ: assert property (
        reg_rd_in |=> reg_rvalid_out ##1
        (reg_rvalid_out == $past(reg_rd_in)))
        else $error("read answer not one cycle after strobe");
endmodule // lcfg_monitor

bind lcfg_top lcfg_monitor u_monitor (.*);

/* sim/tb_top.sv */
// Self-checking bench for the configuration bank top
`timescale 1ns/100ps
module tb_top;
    import lcfg_pkg::*;
    logic       clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, p;
    logic       external_enable_pin_b_in, overcurrent_event_in;
    logic       overtemp_event_in, osc_fault_event_in, anin_hiz_out;
    logic       regulation_mode_select_out, converter_enable_out;
    logic [2:0] adc_source_select_out;
    logic       resistor_disable_out, overcurrent_detect_en_out;
    logic [7:0] overcurrent_threshold_out, programmable_resistor_out;
    logic [9:0] reference_code_out;
    logic       sense_range_select_out, modulation_enable_out;
    logic       vrn_range_select_out, reference_swap_out;
    logic       laser_polarity_select_out, adc_divider_enable_out;
    logic [5:0] converter_current_code_out, sense_gain_factor_out;
    logic [1:0] sense_gain_out;
    logic       reference_curve_select_out, channel_enabled_state_out;
    logic       overtemp_active_out, overcurrent_active_out;
    logic       osc_fault_active_out, fault_check_output_b_out;
    logic       memory_error_flag_out, overcurrent_flag_out;
    int         errors, checked;
    localparam logic [7:0] OFFS [7] = '{8'h10, 8'h11, 8'h12, 8'h13,
                                        8'h14, 8'h15, 8'h16};
    localparam logic [7:0] RSTS [7] = '{8'h08, 8'h00, 8'hFF, 8'h40,
                                        8'h00, 8'h00, 8'h06};
    localparam logic [7:0] MSKS [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hDF,
                                        8'hFF, 8'hFF, 8'hBF};
    localparam logic [7:0] PATS [2] = '{8'h5A, 8'hA5};

    lcfg_top dut (.*);

    initial clk_sys_in = 1'b0;
    always #2 clk_sys_in = ~clk_sys_in;

    task automatic chk(string name, logic [9:0] seen, logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
    endtask
    // Answer stands one cycle, so it is sampled at the next falling edge
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk_sys_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        chk("rvalid", {9'h000, reg_rvalid_out}, 10'h001);
        chk("rdata", {2'h0, reg_rdata_out}, {2'h0, exp});
    endtask
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        tally_and_finish();
    end

    initial begin
        {rst_b_in, reg_wr_in, reg_rd_in, overcurrent_event_in} = 4'h0;
        {overtemp_event_in, osc_fault_event_in} = 2'h0;
        {reg_addr_in, reg_wdata_in} = 16'h0000;
        external_enable_pin_b_in = 1'b1;
        tick(16);
        rst_b_in = 1'b1;
        tick(10);
        for (int i = 0; i < 7; i++) rd(OFFS[i], RSTS[i]);
        rd(OFF_OP_STATE, 8'h05);
        chk("ref_swap", reference_swap_out, 1'b1);
        chk("adc_div", adc_divider_enable_out, 1'b1);
        chk("resistor", programmable_resistor_out, 8'hFF);
        chk("oc_det", overcurrent_detect_en_out, 1'b0);
        chk("curve", reference_curve_select_out, 1'b0);
        chk("range", sense_range_select_out, 1'b0);
        chk("mode", regulation_mode_select_out, 1'b0);
        chk("gain", sense_gain_factor_out, 6'h02);
        foreach (PATS[j]) begin
            p = PATS[j];
            for (int i = 0; i < 7; i++) wr(OFFS[i], p);
            for (int i = 0; i < 7; i++) rd(OFFS[i], p & MSKS[i]);
            tick(3);
            chk("mode", regulation_mode_select_out, p[0]);
            chk("conv_en", converter_enable_out, p[1]);
            chk("adc_src", adc_source_select_out, p[7:5]);
            chk("thr", overcurrent_threshold_out, p);
            chk("resistor", programmable_resistor_out, p);
            chk("ref", reference_code_out, {p[1:0], p});
            chk("range", sense_range_select_out, p[2]);
            chk("res_dis", resistor_disable_out, p[2]);
            chk("mod_en", modulation_enable_out, p[3]);
            chk("vrn", vrn_range_select_out, p[4]);
            chk("pol", laser_polarity_select_out, p[7]);
            chk("ref_swap", reference_swap_out, p[6]);
            chk("conv_cur", converter_current_code_out, p[5:0]);
            chk("gain", sense_gain_out, p[7:6]);
            chk("adc_div", adc_divider_enable_out, p[2]);
            chk("curve", reference_curve_select_out, p[3]);
            chk("ot", overtemp_active_out, p[4]);
            chk("oc", overcurrent_active_out, p[5]);
            chk("osc", osc_fault_active_out, p[7]);
            chk("fchk", fault_check_output_b_out, 1'b1);
        end
        wr(OFF_MASK_SIM, 8'h06);
        tick(4);
        rd(OFF_STATUS, 8'h20);
        rd(OFF_STATUS, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(OFF_CONV_GAIN, {c[1:0], 6'h00});
            tick(3);
            chk("gain_f", sense_gain_factor_out, PATS[0] == 8'h5A ?
                (c == 0 ? 6'h02 : c == 1 ? 6'h05 : c == 2 ? 6'h0A : 6'h32)
                : 6'h00);
        end
        wr(OFF_MASK_SIM, 8'h80);
        tick(3);
        chk("fchk", fault_check_output_b_out, 1'b0);
        wr(OFF_MASK_SIM, 8'h81);
        tick(3);
        chk("fchk", fault_check_output_b_out, 1'b1);
        wr(OFF_MASK_SIM, 8'h00);
        wr(OFF_MODE_ADC, 8'h00);
        external_enable_pin_b_in = 1'b0;
        tick(8);
        chk("ch_on", channel_enabled_state_out, 1'b1);
        chk("fchk", fault_check_output_b_out, 1'b0);
        wr(OFF_MASK_SIM, 8'h12);
        tick(3);
        chk("ch_ot", channel_enabled_state_out, 1'b0);
        chk("fchk", fault_check_output_b_out, 1'b1);
        wr(OFF_MASK_SIM, 8'h06);
        wr(OFF_MODE_ADC, 8'h08);
        tick(3);
        chk("ch_lock", channel_enabled_state_out, 1'b0);
        external_enable_pin_b_in = 1'b1;
        wr(OFF_OC_THR, 8'h00);
        overcurrent_event_in = 1'b1;
        tick(8);
        chk("oc_off", overcurrent_active_out, 1'b0);
        wr(OFF_OC_THR, 8'h01);
        tick(3);
        chk("oc_on", overcurrent_active_out, 1'b1);
        overcurrent_event_in = 1'b0;
        tick(8);
        rd(OFF_STATUS, 8'h20);
        wr(OFF_OP_STATE, 8'h06);
        wr(OFF_REF_LOW, 8'h33);
        tick(3);
        chk("ref_hold", reference_code_out[7:0], 8'hA5);
        chk("memory_error_flag", memory_error_flag_out, 1'b1);
        chk("anin_hiz", anin_hiz_out, 1'b1);
        rd(OFF_REF_LOW, 8'h33);
        wr(OFF_OP_STATE, 8'h05);
        tick(3);
        chk("ref_apply", reference_code_out[7:0], 8'h33);
        chk("memory_error_flag", memory_error_flag_out, 1'b0);
        foreach (PATS[j]) begin
            wr(OFF_OP_STATE, {6'h01, PATS[j][7], PATS[j][7]});
            tick(3);
            rd(OFF_STATUS, 8'h04);
        end
        wr(OFF_OP_STATE, 8'h05);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        rd(OFF_STATUS, 8'h00);
        tally_and_finish();
    end
endmodule // tb_top
